// ### dhp_pkg.sv
// Package of constants for the duart host port block
package dhp_pkg;
   // ---------------------------------------------------------------
   // Register select codes
   // ---------------------------------------------------------------
   localparam logic [3:0] DHP_A_MODE = 4'h0;
   localparam logic [3:0] DHP_A_STAT = 4'h1;
   localparam logic [3:0] DHP_A_THR = 4'h3;
   localparam logic [3:0] DHP_A_ISR = 4'h5;
   localparam logic [3:0] DHP_A_IMR = 4'h5;
   localparam logic [3:0] DHP_B_MODE = 4'h8;
   localparam logic [3:0] DHP_B_STAT = 4'h9;
   localparam logic [3:0] DHP_B_THR = 4'hB;
   localparam logic [3:0] DHP_A_IVR = 4'hC;
   localparam logic [3:0] DHP_A_GPIN = 4'hD;
   localparam logic [3:0] DHP_A_OUTPUT_PORT_CONFIG_REG = 4'hD;
   localparam logic [3:0] DHP_A_OPSET = 4'hE;
   localparam logic [3:0] DHP_A_OPCLR = 4'hF;
   localparam logic [3:0] DHP_A_GPCFG = 4'h2;
   localparam logic [3:0] DHP_A_GPOUT = 4'hA;
   // ---------------------------------------------------------------
   // Reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] DHP_ZERO8 = 8'h00;
   localparam logic [7:0] DHP_ONES8 = 8'hFF;
   localparam logic [7:0] DHP_IVR_RST = 8'h0F;
   localparam logic [15:0] DHP_ZERO16 = 16'h0000;
   localparam logic [1:0] DHP_MRP_FIRST = 2'h0;
   localparam logic [1:0] DHP_MRP_LAST = 2'h1;
   localparam int DHP_ST_TXRDY = 2;
   localparam int DHP_ST_TXEMT = 3;
   localparam int DHP_ISR_TXA = 0;
   localparam int DHP_ISR_TXB = 4;
   localparam int DHP_ISR_GPA = 7;
   localparam int DHP_ISR_GPB = 3;
   localparam logic [3:0] DHP_BITS_LAST = 4'h9;
   localparam logic [3:0] DHP_BAUD_DIV = 4'hF;
endpackage : dhp_pkg

// ### dhp_mem.sv
// Register memory of two channel mode register pairs
`timescale 1ns/1ps
`default_nettype none
module dhp_mem (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Write port
   input wire logic wr_i,
   input wire logic [1:0] waddr_i,
   input wire logic [7:0] wdata_i,
   // Read port
   input wire logic [1:0] raddr_i,
   output logic [7:0] rdata_o
);
   import dhp_pkg::*;
   typedef struct packed {
      logic [3:0][7:0] mem;
      logic [7:0] rd;
   } dhpm_state_t;
   dhpm_state_t s_r;
   dhpm_state_t s_nxt;

   // Write and registered read
   always_comb begin
      s_nxt = s_r;
      if (wr_i) begin
         s_nxt.mem[waddr_i] = wdata_i;
      end
      s_nxt.rd = s_r.mem[raddr_i];
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         // Mode registers keep their contents across reset
         s_r.rd <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rd;
endmodule : dhp_mem
`default_nettype wire

// ### dhp_top.sv
// Host port of a dual channel UART, acknowledge style bus
`timescale 1ns/1ps
`default_nettype none
module dhp_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Bus pins
   input wire logic bus_style_i,
   input wire logic chip_select_low_i,
   input wire logic read_write_select_i,
   input wire logic irq_vector_ack_in_i,
   input wire logic [3:0] register_select_lines_i,
   input wire logic [7:0] host_data_lines_i,
   output logic [7:0] host_data_lines_o,
   output logic host_data_lines_oe_o,
   output logic transfer_ack_out_o,
   output logic transfer_ack_out_oe_o,
   output logic irq_request_out_o,
   output logic irq_request_out_oe_o,
   // Serial pins
   input wire logic serial_in_chan_a_i,
   input wire logic serial_in_chan_b_i,
   output logic serial_out_chan_a_o,
   output logic serial_out_chan_b_o,
   // Channel control
   input wire logic [1:0] tx_enable_i,
   input wire logic [1:0] loopback_i,
   output logic [1:0] rx_bit_o,
   // Ports
   output logic [7:0] output_port_bits_o,
   input wire logic [15:0] gpio_i,
   output logic [15:0] gpio_o,
   output logic [15:0] gpio_oe_o,
   output logic timer_run_o
);
   import dhp_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] bs_s;     // bus style sync
      logic [2:0] cs_s;
      logic [2:0] rw_s;
      logic [2:0] ia_s;
      logic [1:0] rxa_s;
      logic [1:0] rxb_s;
      logic [15:0] gp_s1;
      logic [15:0] gp_s2;
      logic [15:0] gp_prev;
      logic busy;           // current cycle already served
      logic [7:0] dout;
      logic doe;
      logic ack;
      logic [7:0] stat_a;
      logic [7:0] stat_b;
      logic [7:0] irq_mask_reg;
      logic [7:0] irq_status_reg;
      logic [7:0] output_port_reg;
      logic [7:0] output_port_config_reg;
      logic [7:0] ivr;
      logic [15:0] gpcfg;
      logic [15:0] gpout;
      logic [1:0] mrp_a;
      logic [1:0] mrp_b;
      logic timer_run;
      logic [1:0] tx_busy;
      logic [1:0][9:0] tx_sh;
      logic [1:0][3:0] tx_cnt;
      logic [1:0][3:0] tx_div;
      logic [1:0] txd;
   } dhp_state_t;
   dhp_state_t s_r;
   dhp_state_t s_nxt;
   logic mem_wr;
   logic [1:0] mem_waddr;
   logic [1:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic [3:0] addr;
   logic sel;

   // Is this address a channel mode register
   function automatic logic is_mode(input logic [3:0] a);
      is_mode = (a == DHP_A_MODE) || (a == DHP_B_MODE);
   endfunction : is_mode

   assign addr = register_select_lines_i;
   // Acknowledge style bus only when style select low
   assign sel = !s_r.bs_s[2] && !s_r.cs_s[2];
   assign mem_raddr = {addr[3], (addr[3] ? s_r.mrp_b[0] : s_r.mrp_a[0])};

   // ---------------------------------------------------------------
   // Mode register memory
   // ---------------------------------------------------------------
   dhp_mem u_mem (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .wr_i(mem_wr),
      .waddr_i(mem_waddr),
      .wdata_i(host_data_lines_i),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   // Next state logic
   always_comb begin
      s_nxt = s_r;
      mem_wr = 1'b0;
      mem_waddr = mem_raddr;
      // Three-flop synchronisers on bus control pins, two-flop on serial and GPIO inputs
      s_nxt.bs_s = {s_r.bs_s[1:0], bus_style_i};
      s_nxt.cs_s = {s_r.cs_s[1:0], chip_select_low_i};
      s_nxt.rw_s = {s_r.rw_s[1:0], read_write_select_i};
      s_nxt.ia_s = {s_r.ia_s[1:0], irq_vector_ack_in_i};
      s_nxt.rxa_s = {s_r.rxa_s[0], serial_in_chan_a_i};
      s_nxt.rxb_s = {s_r.rxb_s[0], serial_in_chan_b_i};
      s_nxt.gp_s1 = gpio_i;
      s_nxt.gp_s2 = s_r.gp_s1;
      // Change detectors on every pin, outputs included
      s_nxt.gp_prev = s_r.gp_s2;
      if (|(s_r.gp_s2[7:0] ^ s_r.gp_prev[7:0])) begin
         s_nxt.irq_status_reg[DHP_ISR_GPA] = 1'b1;
      end
      if (|(s_r.gp_s2[15:8] ^ s_r.gp_prev[15:8])) begin
         s_nxt.irq_status_reg[DHP_ISR_GPB] = 1'b1;
      end
      // Transmitter ready flags track holding state
      s_nxt.stat_a[DHP_ST_TXRDY] = !s_r.tx_busy[0];
      s_nxt.stat_a[DHP_ST_TXEMT] = !s_r.tx_busy[0];
      s_nxt.stat_b[DHP_ST_TXRDY] = !s_r.tx_busy[1];
      s_nxt.stat_b[DHP_ST_TXEMT] = !s_r.tx_busy[1];
      s_nxt.irq_status_reg[DHP_ISR_TXA] = !s_r.tx_busy[0];
      s_nxt.irq_status_reg[DHP_ISR_TXB] = !s_r.tx_busy[1];
      // End of cycle releases bus and acknowledge, once both selects are high
      if (s_r.bs_s[2] || (s_r.ia_s[2] && s_r.cs_s[2])) begin
         s_nxt.busy = 1'b0;
         s_nxt.doe = 1'b0;
         s_nxt.ack = 1'b0;
      end
      // Interrupt acknowledge drives vector
      if (!s_r.bs_s[2] && !s_r.ia_s[2] && !s_r.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.dout = s_r.ivr;
         s_nxt.doe = 1'b1;
         s_nxt.ack = 1'b1;
      end else if (sel && s_r.ia_s[2] && !s_r.busy) begin
         s_nxt.busy = 1'b1;
         s_nxt.ack = 1'b1;
         if (s_r.rw_s[2]) begin
            // Read cycle, register chosen by address
            s_nxt.doe = 1'b1;
            case (addr)
               DHP_A_MODE, DHP_B_MODE: s_nxt.dout = mem_rdata;
               DHP_A_STAT: s_nxt.dout = s_r.stat_a;
               DHP_B_STAT: s_nxt.dout = s_r.stat_b;
               DHP_A_ISR: s_nxt.dout = s_r.irq_status_reg;
               DHP_A_IVR: s_nxt.dout = s_r.ivr;
               DHP_A_GPIN: begin
                  s_nxt.dout = s_r.gp_s2[7:0];
                  s_nxt.irq_status_reg[DHP_ISR_GPA] = 1'b0;
                  s_nxt.irq_status_reg[DHP_ISR_GPB] = 1'b0;
               end
               DHP_A_GPOUT: s_nxt.dout = s_r.gp_s2[15:8];
               default: s_nxt.dout = DHP_ZERO8;
            endcase
            if (addr == DHP_A_MODE) begin
               s_nxt.mrp_a = DHP_MRP_LAST;
            end
            if (addr == DHP_B_MODE) begin
               s_nxt.mrp_b = DHP_MRP_LAST;
            end
         end else begin
            // Write cycle captures the data bus
            case (addr)
               DHP_A_MODE, DHP_B_MODE: mem_wr = 1'b1;
               DHP_A_IMR: s_nxt.irq_mask_reg = host_data_lines_i;
               DHP_A_THR: begin
                  if (tx_enable_i[0] && !s_r.tx_busy[0]) begin
                     s_nxt.tx_busy[0] = 1'b1;
                     s_nxt.tx_sh[0] = {1'b1, host_data_lines_i, 1'b0};
                     s_nxt.tx_cnt[0] = 4'h0;
                     s_nxt.tx_div[0] = 4'h0;
                  end
               end
               DHP_B_THR: begin
                  if (tx_enable_i[1] && !s_r.tx_busy[1]) begin
                     s_nxt.tx_busy[1] = 1'b1;
                     s_nxt.tx_sh[1] = {1'b1, host_data_lines_i, 1'b0};
                     s_nxt.tx_cnt[1] = 4'h0;
                     s_nxt.tx_div[1] = 4'h0;
                  end
               end
               DHP_A_IVR: s_nxt.ivr = host_data_lines_i;
               DHP_A_OUTPUT_PORT_CONFIG_REG: s_nxt.output_port_config_reg = host_data_lines_i;
               DHP_A_OPSET: s_nxt.output_port_reg = s_r.output_port_reg | host_data_lines_i;
               DHP_A_OPCLR: s_nxt.output_port_reg = s_r.output_port_reg & ~host_data_lines_i;
               DHP_A_GPCFG: s_nxt.gpcfg = {host_data_lines_i,
                                           host_data_lines_i};
               DHP_A_GPOUT: s_nxt.gpout = {host_data_lines_i,
                                           host_data_lines_i};
               default: s_nxt.timer_run = s_r.timer_run;
            endcase
            if (is_mode(addr)) begin
               if (addr == DHP_A_MODE) begin
                  s_nxt.mrp_a = DHP_MRP_LAST;
               end else begin
                  s_nxt.mrp_b = DHP_MRP_LAST;
               end
            end
         end
      end
      // Transmit shifters, LSB first after the start bit
      for (int c = 0; c < 2; c++) begin
         if (!tx_enable_i[c] || !s_r.tx_busy[c]) begin
            s_nxt.txd[c] = 1'b1;
            s_nxt.tx_busy[c] = s_nxt.tx_busy[c] & tx_enable_i[c];
         end else begin
            s_nxt.txd[c] = loopback_i[c] ? 1'b1 : s_r.tx_sh[c][0];
            s_nxt.tx_div[c] = s_r.tx_div[c] + 4'h1;
            if (s_r.tx_div[c] == DHP_BAUD_DIV) begin
               s_nxt.tx_sh[c] = {1'b1, s_r.tx_sh[c][9:1]};
               s_nxt.tx_cnt[c] = s_r.tx_cnt[c] + 4'h1;
               if (s_r.tx_cnt[c] == DHP_BITS_LAST) begin
                  s_nxt.tx_busy[c] = 1'b0;
               end
            end
         end
      end
   end

   // State register with reset side effects
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         s_r <= '0;
         s_r.bs_s <= 3'h7;
         s_r.cs_s <= 3'h7;
         s_r.ia_s <= 3'h7;
         s_r.rxa_s <= 2'h3;
         s_r.rxb_s <= 2'h3;
         s_r.txd <= 2'h3;
         s_r.ivr <= DHP_IVR_RST;
         s_r.mrp_a <= DHP_MRP_FIRST;
         s_r.mrp_b <= DHP_MRP_FIRST;
         s_r.gpcfg <= DHP_ZERO16;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   assign host_data_lines_o = s_r.dout;
   assign host_data_lines_oe_o = s_r.doe && (!s_r.cs_s[2] ||
                                 !s_r.ia_s[2]);
   assign transfer_ack_out_o = 1'b0;
   assign transfer_ack_out_oe_o = s_r.ack;
   // Open drain request from unmasked conditions
   assign irq_request_out_o = 1'b0;
   assign irq_request_out_oe_o = |(s_r.irq_status_reg & s_r.irq_mask_reg);
   assign serial_out_chan_a_o = s_r.txd[0];
   assign serial_out_chan_b_o = s_r.txd[1];
   // Receive samples, high is mark
   assign rx_bit_o = {s_r.rxb_s[1], s_r.rxa_s[1]};
   // Output port pins are the inverse of the register
   assign output_port_bits_o = ~s_r.output_port_reg;
   // GPIO direction per configuration
   assign gpio_o = s_r.gpout;
   assign gpio_oe_o = s_r.gpcfg;
   assign timer_run_o = s_r.timer_run;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_float_unsel: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_r.cs_s[2] && s_r.ia_s[2] |-> !host_data_lines_oe_o)
      else $error("data driven while deselected");
   chk_irq_level: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      irq_request_out_oe_o == |(s_r.irq_status_reg & s_r.irq_mask_reg))
      else $error("irq level wrong");
   chk_write_nodrive: assert property (@(posedge mclk_i)
      disable iff (!nrst_i)
      sel && !s_r.rw_s[2] && s_r.ia_s[2] && !s_r.busy
      |=> !s_r.doe)
      else $error("data driven on write");
   chk_ack_cycle: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      sel && !s_r.busy |=> transfer_ack_out_oe_o)
      else $error("no ack");
   chk_vector_out: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !s_r.bs_s[2] && !s_r.ia_s[2] && !s_r.busy
      |=> host_data_lines_o == $past(s_r.ivr))
      else $error("vector wrong");
   chk_tx_mark: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !tx_enable_i[0] |=> serial_out_chan_a_o)
      else $error("tx not mark");
   chk_op_high: assert property (@(posedge mclk_i)
      $rose(nrst_i) |-> output_port_bits_o == DHP_ONES8)
      else $error("output port not high");
   chk_mrp_first: assert property (@(posedge mclk_i)
      $rose(nrst_i) |-> s_r.mrp_a == DHP_MRP_FIRST)
      else $error("mode pointer not first");
endmodule : dhp_top
`default_nettype wire

// ### dhp_host_model.sv
// Host processor model for the acknowledge style bus
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
   // Clock
   input wire logic mclk_i,
   // Answers from the device
   input wire logic ack_oe_i,
   // Host side of the bus
   output logic cs_n_o,
   output logic rw_o,
   output logic iack_n_o,
   output logic [3:0] addr_o,
   output logic [7:0] data_o,
   output logic fault_o
);
   // ---------------------------------------------------------------
   // Idle bus state
   // ---------------------------------------------------------------
   initial begin
      cs_n_o = 1'b1;
      rw_o = 1'b1;
      iack_n_o = 1'b1;
      addr_o = 4'h0;
      data_o = 8'h00;
      fault_o = 1'b0;
   end

   // ---------------------------------------------------------------
   // One bus cycle: read, write or vector fetch
   // ---------------------------------------------------------------
   task automatic cycle(input logic is_rd, input logic is_iack,
                        input logic [3:0] a, input logic [7:0] d,
                        input logic exp_ack);
      int n;
      int lim;
      n = 0;
      lim = exp_ack ? 40 : 12;
      @(posedge mclk_i);
      cs_n_o <= is_iack; // Select low for register cycles
      iack_n_o <= ~is_iack; // Vector fetch
      rw_o <= is_rd; // High reads, low writes
      addr_o <= a;
      data_o <= d;
      do begin
         @(posedge mclk_i);
         n++;
      end while (ack_oe_i !== 1'b1 && n < lim);
      if (exp_ack ? (n >= lim) : (ack_oe_i === 1'b1)) begin
         fault_o <= 1'b1;
      end
      cs_n_o <= 1'b1;
      iack_n_o <= 1'b1;
      data_o <= ~d; // Released lines show the inverse value
      n = 0;
      while (ack_oe_i !== 1'b0 && n < 40) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 40) begin
         fault_o <= 1'b1;
      end
   endtask : cycle
endmodule : dhp_host_model
`default_nettype wire

// ### dhp_top_tb_top.sv
// Self-checking testbench of the duart host port
`timescale 1ns/1ps
`default_nettype none
module dhp_top_tb_top import dhp_pkg::*; ;
   logic mclk_i, nrst_i, bus_style_i, ack_prev;
   logic cs_n, rw, iack_n, fault;
   logic [3:0] addr;
   logic [7:0] hd, dout, v1, v2, v3;
   logic host_data_lines_oe_o, transfer_ack_out_oe_o, irq_request_out_oe_o;
   logic serial_out_chan_a_o, serial_out_chan_b_o, timer_run_o;
   logic serial_in_chan_a_i, serial_in_chan_b_i;
   logic [1:0] tx_enable_i, loopback_i, rx_bit_o;
   logic [7:0] output_port_bits_o;
   logic [15:0] gpio_i;
   logic [31:0] seed;
   logic [7:0] exp_q[$];
   int mismatches, n_compared;

   // ---------------------------------------------------------------
   // Clock, device and host model
   // ---------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   dhp_top i_dhp_top (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .bus_style_i(bus_style_i), .chip_select_low_i(cs_n),
      .read_write_select_i(rw), .irq_vector_ack_in_i(iack_n),
      .register_select_lines_i(addr),
      .host_data_lines_i(host_data_lines_oe_o ? dout : hd),
      .host_data_lines_o(dout), .host_data_lines_oe_o(host_data_lines_oe_o),
      .transfer_ack_out_o(), .transfer_ack_out_oe_o(transfer_ack_out_oe_o),
      .irq_request_out_o(), .irq_request_out_oe_o(irq_request_out_oe_o),
      .serial_in_chan_a_i(serial_in_chan_a_i),
      .serial_in_chan_b_i(serial_in_chan_b_i),
      .serial_out_chan_a_o(serial_out_chan_a_o),
      .serial_out_chan_b_o(serial_out_chan_b_o),
      .tx_enable_i(tx_enable_i), .loopback_i(loopback_i), .rx_bit_o(rx_bit_o),
      .output_port_bits_o(output_port_bits_o), .gpio_i(gpio_i), .gpio_o(),
      .gpio_oe_o(), .timer_run_o(timer_run_o));

   dhp_host_model i_dhp_host_model (.mclk_i(mclk_i),
      .ack_oe_i(transfer_ack_out_oe_o), .cs_n_o(cs_n), .rw_o(rw),
      .iack_n_o(iack_n), .addr_o(addr), .data_o(hd), .fault_o(fault));

   // ---------------------------------------------------------------
   // Comparison, verdict and bus helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic stop_test();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      i_dhp_host_model.cycle(1'b0, 1'b0, a, d, 1'b1);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic iack,
                     input logic [7:0] e);
      exp_q.push_back(e);
      i_dhp_host_model.cycle(1'b1, iack, a, 8'h00, 1'b1);
   endtask : rd

   // Watcher: each acknowledge with data driven takes the oldest note
   always @(negedge mclk_i) begin
      ack_prev <= transfer_ack_out_oe_o;
      if (ack_prev !== 1'b1 && transfer_ack_out_oe_o === 1'b1
          && host_data_lines_oe_o !== 1'b0) begin
         if (exp_q.size() == 0) begin
            chk("unrequested_drive", 8'h00, 8'hFF);
         end else begin
            chk("read_data", exp_q.pop_front(), dout);
         end
      end
   end

   // A hung or wrongly answered cycle ends the run
   always @(posedge fault) begin
      mismatches++;
      $display("Error bus_cycle expected ack seen none");
      stop_test();
   end

   // Serial frame on channel A, bit 0 high so the start bit is measurable
   task automatic tx_frame(input logic [7:0] v);
      int n;
      int p;
      logic [7:0] got;
      n = 0;
      p = 0;
      while (serial_out_chan_a_o !== 1'b0 && n < 3000) begin
         @(negedge mclk_i);
         n++;
      end
      while (serial_out_chan_a_o === 1'b0 && p < 300) begin
         @(negedge mclk_i);
         p++;
      end
      repeat (p / 2) @(negedge mclk_i);
      for (int i = 0; i < 8; i++) begin
         got[i] = serial_out_chan_a_o;
         repeat (p) @(negedge mclk_i);
      end
      chk("tx_a_byte", v, got);
   endtask : tx_frame

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h1B8FE0D9;
      mismatches = 0;
      n_compared = 0;
      ack_prev = 1'b0;
      nrst_i = 1'b0;
      bus_style_i = 1'b0;
      serial_in_chan_a_i = 1'b1;
      serial_in_chan_b_i = 1'b1;
      tx_enable_i = 2'b00;
      loopback_i = 2'b00;
      gpio_i = 16'h0000;
      repeat (11) @(posedge mclk_i);
      chk("op_bits", 8'hFF, output_port_bits_o);
      chk("serial_out", 8'h03, {6'h00, serial_out_chan_b_o,
          serial_out_chan_a_o});
      chk("timer_irq", 8'h00, {6'h00, timer_run_o, irq_request_out_oe_o});
      chk("bus_oe", 8'h00, {6'h00, host_data_lines_oe_o,
          transfer_ack_out_oe_o});
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      gpio_i <= $random(seed);
      repeat (4) @(posedge mclk_i);
      // Other bus style: no answer to a select
      bus_style_i <= 1'b1;
      i_dhp_host_model.cycle(1'b1, 1'b0, DHP_A_STAT, 8'h00, 1'b0);
      bus_style_i <= 1'b0;
      // Mode pointer returns to the first register after reset
      v1 = $random(seed);
      v2 = $random(seed);
      v3 = $random(seed);
      wr(DHP_A_MODE, v1);
      wr(DHP_A_MODE, v2);
      nrst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      wr(DHP_A_MODE, v3);
      rd(DHP_A_MODE, 1'b0, v2);
      // Output port set and clear, pins show the inverse
      wr(DHP_A_OPSET, v1);
      repeat (3) @(negedge mclk_i);
      chk("op_set", ~v1, output_port_bits_o);
      wr(DHP_A_OPCLR, v1);
      repeat (3) @(negedge mclk_i);
      chk("op_clr", 8'hFF, output_port_bits_o);
      // Vector fetch and vector register read
      rd(4'h0, 1'b1, DHP_IVR_RST);
      wr(DHP_A_IVR, v3);
      rd(4'h0, 1'b1, v3);
      rd(DHP_A_IVR, 1'b0, v3);
      // Interrupt request follows the mask
      wr(DHP_A_IMR, 8'h01 << DHP_ISR_TXA);
      repeat (4) @(negedge mclk_i);
      chk("irq_on", 8'h01, {7'h00, irq_request_out_oe_o});
      wr(DHP_A_IMR, 8'h00);
      repeat (4) @(negedge mclk_i);
      chk("irq_off", 8'h00, {7'h00, irq_request_out_oe_o});
      // Loopback on B and disabled A keep mark
      tx_enable_i <= 2'b10;
      loopback_i <= 2'b10;
      wr(DHP_B_THR, v2);
      wr(DHP_A_THR, v1 | 8'h01);
      for (int i = 0; i < 200; i++) begin
         @(negedge mclk_i);
         if (i % 50 == 0) begin
            chk("tx_mark", 8'h03, {6'h00, serial_out_chan_b_o,
                serial_out_chan_a_o});
         end
      end
      tx_enable_i <= 2'b01;
      loopback_i <= 2'b00;
      @(posedge mclk_i);
      // Load channel A while the frame watcher is already looking
      fork
         wr(DHP_A_THR, v1 | 8'h01);
         tx_frame(v1 | 8'h01);
      join
      // Receive inputs reach the sampled bits
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk_i);
         {serial_in_chan_b_i, serial_in_chan_a_i} <= 2'($random(seed));
         gpio_i <= $random(seed);
         repeat (5) @(negedge mclk_i);
         chk("rx_bit", {6'h00, serial_in_chan_b_i, serial_in_chan_a_i},
             {6'h00, rx_bit_o});
      end
      repeat (5) @(posedge mclk_i);
      stop_test();
   end
endmodule : dhp_top_tb_top
`default_nettype wire
